// ==== bench/irq_seq_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module irq_seq_model
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // Bench commands: trap, vector select, return
    input  wire logic [2:0]              cmd,
    input  wire logic                    slow,
    // Unit link
    input  wire irq_unit_pkg::seq_rsp_t  seq_rsp,
    output var  irq_unit_pkg::seq_req_t  seq_req
);
    logic [15:0] pc_ff;
    logic [3:0]  cyc_ff;
    logic [15:0] stk_q[$];
    // Queue stack, so plain always rather than always_ff
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            seq_req <= '0;
            pc_ff <= 16'h0100;
            cyc_ff <= 4'h0;
            stk_q.delete();
        end
        else
        begin
            cyc_ff <= cyc_ff + 4'h1;
            seq_req.instr_tick <= !slow || cyc_ff[1:0] == 2'h0;
            seq_req.instr_start <= !seq_rsp.take && cyc_ff[1:0] == 2'h2;
            {seq_req.trap_instr, seq_req.vis_exec, seq_req.return_from_irq_exec} <= cmd;
            seq_req.next_pc <= pc_ff;
            if (seq_rsp.push)
                stk_q.push_back(seq_rsp.push_addr);
            if (seq_rsp.pc_load)
                pc_ff <= seq_rsp.pc_addr;
            else if (seq_rsp.pop && stk_q.size() > 0)
                pc_ff <= stk_q.pop_back();
            else if (seq_req.instr_start)
                pc_ff <= pc_ff + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== bench/irq_unit_chk_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module irq_unit_chk
#(
    parameter int ACK_CYCLES = 7
)
(
    // Clock and reset
    input wire logic                               clk_sys,
    input wire logic                               rst,
    // Sequencer link
    input wire irq_unit_pkg::seq_req_t             seq_req,
    input wire irq_unit_pkg::seq_rsp_t             seq_rsp,
    // Sources
    input wire logic [irq_unit_pkg::NUM_SRC-2:0]   src_evt,
    input wire logic [irq_unit_pkg::WAKE_W-1:0]    wake_edge,
    // Register port
    input wire logic [irq_unit_pkg::ADDR_W-1:0]    reg_addr,
    input wire logic [irq_unit_pkg::DATA_W-1:0]    reg_wdata,
    input wire logic                               reg_wr,
    input wire logic                               reg_rd,
    input wire logic [irq_unit_pkg::DATA_W-1:0]    reg_rdata
);
    // ----
    // Ticks seen during one acknowledge
    // ----
    logic [7:0] tick_cnt_ff;
    logic [7:0] nxt_tick_cnt;
    assign nxt_tick_cnt = seq_rsp.take ? tick_cnt_ff + 8'(seq_req.instr_tick) : 8'h00;
    always_ff @(posedge clk_sys)
    begin
        tick_cnt_ff <= rst ? 8'h00 : nxt_tick_cnt;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_vis_rsp;
        seq_rsp.vis_valid && !seq_rsp.vis_low[0] && seq_rsp.vis_low[7:5] == 3'h7;
    endsequence
    sequence s_ack_cause;
        seq_rsp.push ##0 $past(seq_req.instr_start) && !$past(seq_rsp.take);
    endsequence
    property p_svc_addr;
        seq_rsp.pc_load |-> seq_rsp.pc_addr == irq_unit_pkg::SERVICE_ADDR;
    endproperty
    property p_ack_len;
        seq_rsp.pc_load |-> tick_cnt_ff == ACK_CYCLES && !seq_rsp.take && $past(seq_rsp.take);
    endproperty
    property p_push_rtn;
        $rose(seq_rsp.take) |-> seq_rsp.push && seq_rsp.push_addr == $past(seq_req.next_pc);
    endproperty
    property p_ack_edge;
        seq_rsp.push |-> s_ack_cause;
    endproperty
    property p_vis;
        seq_req.vis_exec |=> s_vis_rsp;
    endproperty
    property p_rtn_pop;
        seq_req.return_from_irq_exec |=> seq_rsp.pop;
    endproperty
    property p_pop_cause;
        seq_rsp.pop |-> $past(seq_req.return_from_irq_exec);
    endproperty
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_svc_addr: assert property (p_svc_addr) else $error("service address wrong");
    a_ack_len: assert property (p_ack_len) else $error("acknowledge length wrong");
    a_push_rtn: assert property (p_push_rtn) else $error("return address not pushed");
    a_ack_edge: assert property (p_ack_edge) else $error("acknowledge off boundary");
    a_vis: assert property (p_vis) else $error("vector byte bad");
    a_rtn_pop: assert property (p_rtn_pop) else $error("no pop after return");
    a_pop_cause: assert property (p_pop_cause) else $error("pop without return");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule
`default_nettype wire

// ==== bench/vectored_interrupt_unit_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
bind vectored_interrupt_unit irq_unit_chk #(.ACK_CYCLES(ACK_CYCLES)) u_irq_unit_chk (.clk_sys(clk_sys),
    .rst(rst), .seq_req(seq_req), .seq_rsp(seq_rsp), .src_evt(src_evt), .wake_edge(wake_edge),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
module vectored_interrupt_unit_tb_top;
    logic                   clk_sys, rst, reg_wr, reg_rd, slow;
    logic [6:0]             src_evt;
    logic [7:0]             wake_edge, reg_addr, reg_wdata, reg_rdata, got, pe, en, wk, wke, act;
    logic [2:0]             cmd;
    logic [31:0]            seed_v;
    int                     error_cnt, samples_checked;
    irq_unit_pkg::seq_req_t req;
    irq_unit_pkg::seq_rsp_t rsp;
    vectored_interrupt_unit #(.ACK_CYCLES(2)) u_vectored_interrupt_unit (.clk_sys(clk_sys), .rst(rst),
        .seq_req(req), .seq_rsp(rsp), .src_evt(src_evt), .wake_edge(wake_edge), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    irq_seq_model u_irq_seq_model (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .slow(slow),
        .seq_rsp(rsp), .seq_req(req));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ----
    // Helpers
    // ----
    task chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Read data stands only in the cycle after the strobe
        #1 got = reg_rdata;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(got, e);
    endtask
    task pulse(input logic [2:0] c);
        @(posedge clk_sys);
        cmd <= c;
        @(posedge clk_sys);
        cmd <= 3'h0;
    endtask
    task evt(input logic [6:0] s, input logic [7:0] w);
        @(posedge clk_sys);
        src_evt <= s;
        wake_edge <= w;
        @(posedge clk_sys);
        src_evt <= 7'h00;
        wake_edge <= 8'h00;
    endtask
    task vis_chk(input logic [7:0] e);
        pulse(3'h2);
        @(posedge clk_sys);
        #1 chk(rsp.vis_low, e);
    endtask
    task wait_take(input logic v);
        int n;
        n = 0;
        while (rsp.take !== v && n < 200)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(8'(rsp.take), 8'(v));
    endtask
    // Bench view of arbitration: lowest index wins, default vector when idle
    function automatic logic [7:0] top_vec(input logic [7:0] a);
        top_vec = irq_unit_pkg::VEC_DEFAULT;
        for (int i = 7; i >= 0; i--)
            if (a[i]) top_vec = irq_unit_pkg::SRC_VEC[8*i +: 8];
    endfunction
    task print_verdict;
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        print_verdict;
    end
    // ----
    // Main sequence
    // ----
    initial
    begin
        {rst, reg_wr, reg_rd, slow, src_evt, wake_edge, reg_addr, reg_wdata, cmd} = '1;
        {reg_wr, reg_rd, slow, src_evt, wake_edge, reg_addr, reg_wdata, cmd} = '0;
        seed_v = $urandom(32'h61cd);
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++)
            rd(8'(a), irq_unit_pkg::REG_RST);
        for (int k = 0; k < 8; k++)
        begin
            pe = k == 0 ? 8'h00 : 8'($urandom);
            wk = k == 0 ? 8'h00 : 8'($urandom);
            en = 8'($urandom);
            wke = 8'($urandom);
            bus(1'b1, irq_unit_pkg::REG_PEND, 8'h00);
            bus(1'b1, irq_unit_pkg::REG_WAKEUP_PENDING_FLAGS, 8'h00);
            evt(pe[6:0], wk);
            bus(1'b1, irq_unit_pkg::REG_EN, en);
            bus(1'b1, irq_unit_pkg::REG_WKEN, wke);
            rd(irq_unit_pkg::REG_PEND, {|wk, pe[6:0]});
            rd(irq_unit_pkg::REG_EN, en);
            act = {en[7] && |(wk & wke), pe[6:0] & en[6:0]};
            vis_chk(top_vec(act));
        end
        // Acknowledge with slow instruction pacing
        slow <= 1'b1;
        bus(1'b1, irq_unit_pkg::REG_WKEN, 8'h00);
        bus(1'b1, irq_unit_pkg::REG_EN, 8'h03);
        bus(1'b1, irq_unit_pkg::REG_PEND, 8'h02);
        wait_take(1'b0);
        bus(1'b1, irq_unit_pkg::REG_PSW, 8'h01);
        wait_take(1'b1);
        rd(irq_unit_pkg::REG_PSW, 8'h00);
        evt(7'h01, 8'h00);
        wait_take(1'b0);
        bus(1'b1, irq_unit_pkg::REG_PEND, 8'h01);
        vis_chk(8'hfa);
        pulse(3'h1);
        wait_take(1'b1);
        wait_take(1'b0);
        bus(1'b1, irq_unit_pkg::REG_PEND, 8'h02);
        repeat (12) @(posedge clk_sys);
        #1 chk(8'(rsp.take), 8'h00);
        bus(1'b1, irq_unit_pkg::REG_PSW, 8'h01);
        wait_take(1'b1);
        wait_take(1'b0);
        bus(1'b1, irq_unit_pkg::REG_PEND, 8'h00);
        pulse(3'h1);
        pulse(3'h1);
        // Software trap with prompt pacing
        slow <= 1'b0;
        bus(1'b1, irq_unit_pkg::REG_PSW, 8'h00);
        bus(1'b1, irq_unit_pkg::REG_PEND, 8'h01);
        pulse(3'h4);
        wait_take(1'b1);
        rd(irq_unit_pkg::REG_PSW, 8'h06);
        wait_take(1'b0);
        vis_chk(irq_unit_pkg::VEC_TRAP);
        bus(1'b1, irq_unit_pkg::REG_PSW, 8'h01);
        repeat (12) @(posedge clk_sys);
        #1 chk(8'(rsp.take), 8'h00);
        pulse(3'h1);
        wait_take(1'b1);
        wait_take(1'b0);
        print_verdict;
    end
endmodule
`default_nettype wire

// ==== rtl/irq_unit_pkg.sv ====
package irq_unit_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_SRC = 8;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int WAKE_W  = 8;
    localparam int PC_W    = 16;
    localparam int CNT_W   = 3;

    // ----------------------------------------
    // Addresses and vectors
    // ----------------------------------------
    localparam logic [PC_W-1:0] SERVICE_ADDR = 16'h00ff;
    localparam logic [7:0]      VEC_TRAP     = 8'hfe;
    localparam logic [7:0]      VEC_DEFAULT  = 8'he0;
    // Index 0 is highest rank; index 7 is the wakeup port group
    localparam logic [8*NUM_SRC-1:0] SRC_VEC = {8'he2, 8'hea, 8'hf0, 8'hf2, 8'hf4, 8'hf6, 8'hf8, 8'hfa};

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] REG_PEND  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_EN    = 8'h01;
    localparam logic [ADDR_W-1:0] REG_PSW   = 8'h02;
    localparam logic [ADDR_W-1:0] REG_WAKEUP_PENDING_FLAGS = 8'h03;
    localparam logic [ADDR_W-1:0] REG_WKEN  = 8'h04;
    localparam int                PSW_GIE   = 0;
    localparam int                PSW_NMI   = 1;
    localparam int                PSW_TRAP  = 2;
    localparam logic [DATA_W-1:0] REG_RST   = 8'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int ACK_INSTR_CYCLES = 7;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK  = 2'b01
    } ack_state_t;

    typedef struct packed {
        logic            instr_start;
        logic            instr_tick;
        logic            trap_instr;
        logic            vis_exec;
        logic            return_from_irq_exec;
        logic [PC_W-1:0] next_pc;
    } seq_req_t;

    typedef struct packed {
        logic            take;
        logic            push;
        logic [PC_W-1:0] push_addr;
        logic            pc_load;
        logic [PC_W-1:0] pc_addr;
        logic            vis_valid;
        logic [7:0]      vis_low;
        logic            pop;
    } seq_rsp_t;

endpackage

// ==== rtl/vectored_interrupt_unit.sv ====
// What this block does
// R01 - Every acknowledgment ends by loading the program counter with 00FF.
// R02 - Software trap ranks highest; the default vector-select entry ranks lowest.
// R03 - Eight maskable inputs have fixed ranks and fixed vectors.
// R04 - All sources but the trap are maskable, each with enable and pending.
// R05 - A pending flag sets on its event and holds until software clears it.
// R06 - Maskable request needs enable, global enable, no trap routine, instruction start.
// R07 - Simultaneous qualifiers: highest rank served, others stay pending.
// R08 - Reset clears all pending flags, enables and the global enable.
// R09 - Enabling a source already pending triggers at once.
// R10 - Software clears a stale pending flag before enabling its source.
// R11 - A maskable source is active when enabled and pending.
// R12 - Requests are taken at the next instruction start, after any skip.
// R13 - Acknowledgment clears the global enable first.
// R14 - Acknowledgment pushes the address of the next instruction.
// R15 - The whole acknowledgment takes seven instruction cycles.
// R16 - Software writing global enable to one in a routine permits nesting.
// R17 - Return-from-interrupt sets global enable and pops the saved address.
// R18 - Remaining pending requests are served straight after a return.
// R19 - Service routines clear their pending flag early.
// R20 - Pending flags and enables are readable and writable registers.
// R21 - Vector select yields an even E0..FE byte for the top active source.
// R22 - With nothing active, vector select yields the lowest vector.
// R23 - Wakeup port group enable gates the wakeup pending flags.
// R24 - A trap-in-progress flag sets on trap acknowledgment, clears on its return.
`timescale 1ns/10ps
`default_nettype none

module vectored_interrupt_unit
#(
    parameter int ACK_CYCLES = irq_unit_pkg::ACK_INSTR_CYCLES
)
(
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // Instruction sequencer
    input  wire irq_unit_pkg::seq_req_t            seq_req,
    output var  irq_unit_pkg::seq_rsp_t            seq_rsp,
    // Peripheral sources, one-cycle pulses
    input  wire logic [irq_unit_pkg::NUM_SRC-2:0]  src_evt,
    input  wire logic [irq_unit_pkg::WAKE_W-1:0]   wake_edge,
    // Register port
    input  wire logic [irq_unit_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [irq_unit_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output var  logic [irq_unit_pkg::DATA_W-1:0]   reg_rdata
);

    localparam int NF = irq_unit_pkg::NUM_SRC - 1;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Vector table and register layout are built for exactly eight sources
    if (irq_unit_pkg::NUM_SRC != 8)
    begin : g_bad_src
        $error("vectored_interrupt_unit: source count must be 8");
    end
    if (ACK_CYCLES < 1 || ACK_CYCLES > (1 << irq_unit_pkg::CNT_W))
    begin : g_bad_ack
        $error("vectored_interrupt_unit: ACK_CYCLES out of range");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [NF-1:0]                          pend_ff;
    logic [NF-1:0]                          en_ff;
    logic                                   wakeup_port_irq_enable_ff;
    logic                                   gie_ff;
    logic                                   nmi_busy_ff;
    logic                                   trap_pend_ff;
    logic [irq_unit_pkg::WAKE_W-1:0]        wakeup_pending_flags_ff;
    logic [irq_unit_pkg::WAKE_W-1:0]        wken_ff;
    irq_unit_pkg::ack_state_t               state_ff;
    logic [irq_unit_pkg::CNT_W-1:0]         cnt_ff;
    irq_unit_pkg::seq_rsp_t                 rsp_ff;
    logic [irq_unit_pkg::DATA_W-1:0]        rdata_ff;

    logic [NF-1:0]                          nxt_pend;
    logic [NF-1:0]                          nxt_en;
    logic                                   nxt_wakeup_port_irq_enable;
    logic                                   nxt_gie;
    logic                                   nxt_nmi_busy;
    logic                                   nxt_trap_pend;
    logic [irq_unit_pkg::WAKE_W-1:0]        nxt_wakeup_pending_flags;
    logic [irq_unit_pkg::WAKE_W-1:0]        nxt_wken;
    irq_unit_pkg::ack_state_t               nxt_state;
    logic [irq_unit_pkg::CNT_W-1:0]         nxt_cnt;
    irq_unit_pkg::seq_rsp_t                 nxt_rsp;
    logic [irq_unit_pkg::DATA_W-1:0]        nxt_rdata;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire logic wr_pend  = reg_wr && (reg_addr == irq_unit_pkg::REG_PEND);
    wire logic wr_en    = reg_wr && (reg_addr == irq_unit_pkg::REG_EN);
    wire logic wr_psw   = reg_wr && (reg_addr == irq_unit_pkg::REG_PSW);
    wire logic wr_wakeup_pending_flags = reg_wr && (reg_addr == irq_unit_pkg::REG_WAKEUP_PENDING_FLAGS);
    wire logic wr_wken  = reg_wr && (reg_addr == irq_unit_pkg::REG_WKEN);

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    // Wakeup group has no flag of its own; its pending bits stand in
    wire logic                              portl_active = wakeup_port_irq_enable_ff && |(wakeup_pending_flags_ff & wken_ff); // R23
    wire logic [irq_unit_pkg::NUM_SRC-1:0]  active       = {portl_active, pend_ff & en_ff}; // R11 R04
    wire logic                              trap_go      = trap_pend_ff && !nmi_busy_ff;
    wire logic                              mask_go      = (|active) && gie_ff && !nmi_busy_ff; // R06 R09
    wire logic                              idle         = (state_ff == irq_unit_pkg::ST_IDLE);
    // Sequencer raises instr_start only once any skip is done
    wire logic                              ack_start    = idle && seq_req.instr_start && (trap_go || mask_go); // R12 R18
    wire logic                              ack_tick     = (state_ff == irq_unit_pkg::ST_ACK) && seq_req.instr_tick;
    wire logic                              ack_last     = ack_tick
                                                         && (cnt_ff == irq_unit_pkg::CNT_W'(ACK_CYCLES - 1)); // R15
    wire logic                              trap_return_from_irq    = seq_req.return_from_irq_exec && nmi_busy_ff;

    // Scan from lowest rank upward so the highest rank wins
    function automatic logic [7:0] pick_vec(input logic [irq_unit_pkg::NUM_SRC-1:0] act);
        logic [7:0] v;
        v = irq_unit_pkg::VEC_DEFAULT; // R22
        for (int i = irq_unit_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (act[i])
            begin
                v = irq_unit_pkg::SRC_VEC[8*i +: 8]; // R03 R07
            end
        end
        return v;
    endfunction

    wire logic [7:0] vis_vec = trap_pend_ff ? irq_unit_pkg::VEC_TRAP : pick_vec(active); // R02 R21

    // ----------------------------------------
    // Flags and enables
    // ----------------------------------------
    // Hardware set wins over a software write in the same cycle
    assign nxt_pend  = (wr_pend ? reg_wdata[NF-1:0] : pend_ff) | src_evt; // R05 R20
    assign nxt_en    = wr_en ? reg_wdata[NF-1:0] : en_ff; // R20
    assign nxt_wakeup_port_irq_enable  = wr_en ? reg_wdata[NF] : wakeup_port_irq_enable_ff; // R23
    assign nxt_wakeup_pending_flags = (wr_wakeup_pending_flags ? reg_wdata : wakeup_pending_flags_ff) | wake_edge;
    assign nxt_wken  = wr_wken ? reg_wdata : wken_ff;

    // Acknowledgment outranks a return or write in the same cycle
    assign nxt_gie = ack_start              ? 1'b0 :                              // R13
                     seq_req.return_from_irq_exec      ? 1'b1 :                              // R17
                     wr_psw                 ? reg_wdata[irq_unit_pkg::PSW_GIE] :  // R16
                                              gie_ff;

    // Trap flag held through its routine so vector select still reports it
    assign nxt_trap_pend = seq_req.trap_instr || (trap_pend_ff && !trap_return_from_irq);
    assign nxt_nmi_busy  = (ack_start && trap_go) || (nmi_busy_ff && !seq_req.return_from_irq_exec); // R24

    // ----------------------------------------
    // Acknowledge sequence
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            irq_unit_pkg::ST_IDLE:
            begin
                nxt_cnt = '0;
                if (ack_start)
                begin
                    nxt_state = irq_unit_pkg::ST_ACK;
                end
            end
            irq_unit_pkg::ST_ACK:
            begin
                if (ack_last)
                begin
                    nxt_state = irq_unit_pkg::ST_IDLE;
                    nxt_cnt   = '0;
                end
                else if (ack_tick)
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            default:
            begin
                nxt_state = irq_unit_pkg::ST_IDLE;
                nxt_cnt   = '0;
            end
        endcase
    end

    always_comb
    begin
        nxt_rsp           = rsp_ff;
        nxt_rsp.take      = (nxt_state == irq_unit_pkg::ST_ACK);
        nxt_rsp.push      = ack_start; // R14
        nxt_rsp.pc_load   = ack_last;
        nxt_rsp.pc_addr   = irq_unit_pkg::SERVICE_ADDR; // R01
        nxt_rsp.vis_valid = seq_req.vis_exec;
        nxt_rsp.pop       = seq_req.return_from_irq_exec; // R17
        if (ack_start)
        begin
            nxt_rsp.push_addr = seq_req.next_pc; // R14
        end
        if (seq_req.vis_exec)
        begin
            nxt_rsp.vis_low = vis_vec; // R21
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Unmapped reads return zero; read data holds only one cycle
    always_comb
    begin
        nxt_rdata = irq_unit_pkg::REG_RST;
        if (reg_rd)
        begin
            case (reg_addr)
                irq_unit_pkg::REG_PEND:  nxt_rdata = {|wakeup_pending_flags_ff, pend_ff};
                irq_unit_pkg::REG_EN:    nxt_rdata = {wakeup_port_irq_enable_ff, en_ff};
                irq_unit_pkg::REG_PSW:
                begin
                    nxt_rdata[irq_unit_pkg::PSW_GIE]  = gie_ff;
                    nxt_rdata[irq_unit_pkg::PSW_NMI]  = nmi_busy_ff;
                    nxt_rdata[irq_unit_pkg::PSW_TRAP] = trap_pend_ff;
                end
                irq_unit_pkg::REG_WAKEUP_PENDING_FLAGS: nxt_rdata = wakeup_pending_flags_ff;
                irq_unit_pkg::REG_WKEN:  nxt_rdata = wken_ff;
                default:                 nxt_rdata = irq_unit_pkg::REG_RST;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pend_ff <= '0; // R08
        end
        else
        begin
            pend_ff <= nxt_pend;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            en_ff <= '0; // R08
        end
        else
        begin
            en_ff <= nxt_en;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wakeup_port_irq_enable_ff <= 1'b0;
        end
        else
        begin
            wakeup_port_irq_enable_ff <= nxt_wakeup_port_irq_enable;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            gie_ff <= 1'b0; // R08
        end
        else
        begin
            gie_ff <= nxt_gie;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            nmi_busy_ff <= 1'b0;
        end
        else
        begin
            nmi_busy_ff <= nxt_nmi_busy;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            trap_pend_ff <= 1'b0;
        end
        else
        begin
            trap_pend_ff <= nxt_trap_pend;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wakeup_pending_flags_ff <= '0;
        end
        else
        begin
            wakeup_pending_flags_ff <= nxt_wakeup_pending_flags;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wken_ff <= '0;
        end
        else
        begin
            wken_ff <= nxt_wken;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff <= irq_unit_pkg::ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_ff <= '0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rsp_ff <= '0;
        end
        else
        begin
            rsp_ff <= nxt_rsp;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdata_ff <= irq_unit_pkg::REG_RST;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign seq_rsp   = rsp_ff;
    assign reg_rdata = rdata_ff;

endmodule

`default_nettype wire
